// ---- tcc_pkg.sv ----
package tcc_pkg;

  // -------------------------------------------------------------------------
  // register byte addresses on the bus
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_CCA = 8'h04;
  localparam logic [7:0] ADDR_CCB = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_CAPCTL = 8'h10;
  localparam logic [7:0] ADDR_PRESC = 8'h14;
  localparam logic [7:0] ADDR_OUTCTL = 8'h18;
  localparam logic [7:0] ADDR_PINSTAT = 8'h1C;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int MODE_OVF_BIT = 0;
  localparam int MODE_CLRSEL_BIT = 1;
  localparam int MODE_RUN_LO_BIT = 2;
  localparam int MODE_RUN_HI_BIT = 3;
  localparam int CAPA_MODE_BIT = 0;
  localparam int CAPA_TRIG_BIT = 1;
  localparam int CAPB_MODE_BIT = 2;
  localparam int PRESC_CLK_LSB = 0;
  localparam int PRESC_EDGE_A_LSB = 4;
  localparam int PRESC_EDGE_B_LSB = 6;
  localparam int OUT_EN_BIT = 0;
  localparam int OUT_INV_A_BIT = 1;
  localparam int OUT_RESET_BIT = 2;
  localparam int OUT_SET_BIT = 3;
  localparam int OUT_INV_B_BIT = 4;
  localparam int OUT_OS_EN_BIT = 5;
  localparam int OUT_OS_TRIG_BIT = 6;

  // -------------------------------------------------------------------------
  // reset values and masks
  // -------------------------------------------------------------------------
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] CC_RST = 16'h0000;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'h0E;
  localparam logic [7:0] CAPCTL_WMASK = 8'h07;
  localparam logic [7:0] PRESC_WMASK = 8'hF3;
  localparam logic [7:0] OUTCTL_WMASK = 8'h33;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RUN_STOP = 2'b00,
    RUN_FREE = 2'b01,
    RUN_CLR_EDGE = 2'b10,
    RUN_CLR_MATCH = 2'b11
  } tcc_run_e;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BAD = 2'b10,
    EDGE_BOTH = 2'b11
  } tcc_edge_e;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_RDWAIT = 1'b1
  } tcc_bus_e;

  typedef struct packed {
    logic rise;
    logic fall;
  } tcc_edge_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic mapped;
    logic [7:0] addr;
  } tcc_aphase_s;

endpackage

// ---- tcc_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module tcc_props (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic shared_port_pin_oe,
  input wire logic irq_match_a,
  input wire logic irq_match_b
);
  // ---------------------------------------------------------------
  // bus phase tracking
  // ---------------------------------------------------------------
  logic taken;
  logic bad_addr;
  logic rd_bad_r;
  logic rd_bad_nxt;
  logic wr_out_r;
  logic wr_out_nxt;
  assign taken = hsel && htrans[1] && hready;
  assign bad_addr = (haddr[31:8] != 24'h000000) || (haddr[1:0] != 2'h0)
    || (haddr[7:0] > tcc_pkg::ADDR_PINSTAT)
    || (hsize != tcc_pkg::HSIZE_WORD);
  assign rd_bad_nxt = (taken && !hwrite) ? bad_addr
    : (hreadyout ? 1'b0 : rd_bad_r);
  assign wr_out_nxt = taken && hwrite
    && (haddr[7:0] == tcc_pkg::ADDR_OUTCTL);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_bad_r <= 1'b0;
      wr_out_r <= 1'b0;
    end else begin
      rd_bad_r <= rd_bad_nxt;
      wr_out_r <= wr_out_nxt;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  wait_once_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  unmapped_zero_a: assert property (rd_bad_r && hreadyout |-> hrdata == 0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (
    $rose(hreadyout) |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  irq_a_pulse_a: assert property (irq_match_a |=> !irq_match_a)
    else $error("irq a longer than one cycle");
  irq_b_pulse_a: assert property (irq_match_b |=> !irq_match_b)
    else $error("irq b longer than one cycle");
  pin_dir_a: assert property (
    $changed(shared_port_pin_oe) |-> $past(wr_out_r) || $past(wr_out_r, 2))
    else $error("pin direction changed without write");
endmodule
bind tcc_top tcc_props u_props (.clock, .reset_n, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hready, .hrdata, .hreadyout, .hresp,
  .shared_port_pin_oe, .irq_match_a, .irq_match_b);
`default_nettype wire

// ---- tcc_pulse_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module tcc_pulse_src (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [7:0] width,
  output logic pin
);
  // ---------------------------------------------------------------
  // one high pulse of width clocks per request
  // ---------------------------------------------------------------
  logic [7:0] left_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      left_r <= 8'h00;
    else if (go)
      left_r <= width;
    else if (left_r != 8'h00)
      left_r <= left_r - 8'h01;
  end
  assign pin = (left_r != 8'h00);
endmodule
`default_nettype wire

// ---- tcc_top.sv ----
// How it works
// - read-only 16-bit up_counter counts once per selected count clock tick
// - up_counter is zero at reset and while both run mode bits are zero
// - edge-clear mode: valid timer_input_a edge clears up_counter
// - match-clear mode: up_counter equal to capcmp_reg_a clears up_counter
// - in one-shot mode, writing oneshot_sw_trigger clears up_counter
// - capa_mode_sel (bit 0) picks capture or compare for capcmp_reg_a
// - compare: capcmp_reg_a match raises irq_match_a; held until rewritten
// - capture from input a uses the opposite edge; code 11 captures nothing
// - capture from input b uses the selected edge itself, both for 11
// - edge field a sits at bits 5:4, field b at bits 7:6
// - zero compare matches on 0000 to 0001 after overflow, not at overflow
// - zero compare value also matches one count after any clear
// - shared pin is either input b or timer output, never both
// - captures always store the true count; capture beats a write
// - capb_mode_sel (bit 2) picks capture or compare for capcmp_reg_b
// - compare: capcmp_reg_b match raises irq_match_b; value held
// - capcmp_reg_b captures on the selected timer_input_a edge
// - zero capcmp_reg_b matches one count after overflow or any clear
// - capcmp_reg_b may be rewritten while running; new value used
// - counter runs while run mode bits are nonzero, stops when zero
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module tcc_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timer_input_a,
  input wire logic shared_port_pin_in,
  output logic shared_port_pin_out,
  output logic shared_port_pin_oe,
  output logic irq_match_a,
  output logic irq_match_b
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] cca_r;
  logic [15:0] cca_nxt;
  logic [15:0] ccb_r;
  logic [15:0] ccb_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] capctl_r;
  logic [7:0] presc_r;
  logic [7:0] outctl_r;
  logic out_ff_r;
  logic out_ff_nxt;
  logic [2:0] div_r;
  logic [1:0] sync_a_r;
  logic [1:0] sync_b_r;
  logic samp_a_r;
  logic samp_b_r;
  logic irq_a_r;
  logic irq_b_r;
  tcc_pkg::tcc_aphase_s aph_r;
  tcc_pkg::tcc_bus_e bus_st_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  // -------------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------------
  wire aphase_ok;
  wire aphase_map;
  wire wr_go;
  wire wr_count;
  wire wr_cca;
  wire wr_ccb;
  wire wr_mode;
  wire wr_capctl;
  wire wr_presc;
  wire wr_outctl;
  wire [7:0] wd8;
  wire [15:0] wd16;
  logic [31:0] rd_mux;

  assign aphase_ok = hsel & htrans[1] & hready;
  assign aphase_map = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0)
                      & (hsize == tcc_pkg::HSIZE_WORD);
  assign wr_go = aph_r.valid & aph_r.write & aph_r.mapped & hready;
  assign wr_count = wr_go & (aph_r.addr == tcc_pkg::ADDR_COUNT);
  assign wr_cca = wr_go & (aph_r.addr == tcc_pkg::ADDR_CCA);
  assign wr_ccb = wr_go & (aph_r.addr == tcc_pkg::ADDR_CCB);
  assign wr_mode = wr_go & (aph_r.addr == tcc_pkg::ADDR_MODE);
  assign wr_capctl = wr_go & (aph_r.addr == tcc_pkg::ADDR_CAPCTL);
  assign wr_presc = wr_go & (aph_r.addr == tcc_pkg::ADDR_PRESC);
  assign wr_outctl = wr_go & (aph_r.addr == tcc_pkg::ADDR_OUTCTL);
  assign wd8 = hwdata[7:0];
  assign wd16 = hwdata[15:0];

  always_comb begin
    rd_mux = 32'h00000000;
    if (aph_r.mapped) begin
      case (aph_r.addr)
        tcc_pkg::ADDR_COUNT: rd_mux = {16'h0000, count_r};
        tcc_pkg::ADDR_CCA: rd_mux = {16'h0000, cca_r};
        tcc_pkg::ADDR_CCB: rd_mux = {16'h0000, ccb_r};
        tcc_pkg::ADDR_MODE: rd_mux = {24'h000000, mode_r};
        tcc_pkg::ADDR_CAPCTL: rd_mux = {24'h000000, capctl_r};
        tcc_pkg::ADDR_PRESC: rd_mux = {24'h000000, presc_r};
        tcc_pkg::ADDR_OUTCTL: rd_mux = {24'h000000, outctl_r};
        tcc_pkg::ADDR_PINSTAT: rd_mux = {29'h0000000, out_ff_r, samp_b_r,
                                         samp_a_r};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // control fields
  // -------------------------------------------------------------------------
  wire [1:0] run_bits;
  wire running;
  wire clr_sel;
  wire capa_mode;
  wire capa_trig;
  wire capb_mode;
  wire [1:0] clk_sel;
  wire [1:0] edge_a_code;
  wire [1:0] edge_b_code;
  wire out_en;

  assign run_bits = {mode_r[tcc_pkg::MODE_RUN_HI_BIT],
                     mode_r[tcc_pkg::MODE_RUN_LO_BIT]};
  assign running = (run_bits != tcc_pkg::RUN_STOP);
  assign clr_sel = mode_r[tcc_pkg::MODE_CLRSEL_BIT];
  assign capa_mode = capctl_r[tcc_pkg::CAPA_MODE_BIT];
  assign capa_trig = capctl_r[tcc_pkg::CAPA_TRIG_BIT];
  assign capb_mode = capctl_r[tcc_pkg::CAPB_MODE_BIT];
  assign clk_sel = presc_r[tcc_pkg::PRESC_CLK_LSB +: 2];
  assign edge_a_code = presc_r[tcc_pkg::PRESC_EDGE_A_LSB +: 2];
  assign edge_b_code = presc_r[tcc_pkg::PRESC_EDGE_B_LSB +: 2];
  assign out_en = outctl_r[tcc_pkg::OUT_EN_BIT];

  // -------------------------------------------------------------------------
  // count clock enable
  // -------------------------------------------------------------------------
  wire tick;

  assign tick = (clk_sel == 2'h0) ? 1'b1 :
                (clk_sel == 2'h1) ? div_r[0] :
                (clk_sel == 2'h2) ? (&div_r[1:0]) : (&div_r);

  // -------------------------------------------------------------------------
  // input edges
  // -------------------------------------------------------------------------
  tcc_pkg::tcc_edge_s edge_a;
  tcc_pkg::tcc_edge_s edge_b;
  wire b_is_input;
  wire valid_a;
  wire valid_b;
  wire rev_a;

  assign b_is_input = ~out_en;
  assign edge_a.rise = tick & sync_a_r[1] & ~samp_a_r;
  assign edge_a.fall = tick & ~sync_a_r[1] & samp_a_r;
  assign edge_b.rise = tick & b_is_input & sync_b_r[1] & ~samp_b_r;
  assign edge_b.fall = tick & b_is_input & ~sync_b_r[1] & samp_b_r;

  // edge code 10 is never programmed and selects no edge
  assign valid_a = ((edge_a_code == tcc_pkg::EDGE_FALL) & edge_a.fall)
                 | ((edge_a_code == tcc_pkg::EDGE_RISE) & edge_a.rise)
                 | ((edge_a_code == tcc_pkg::EDGE_BOTH)
                    & (edge_a.rise | edge_a.fall));
  assign valid_b = ((edge_b_code == tcc_pkg::EDGE_FALL) & edge_b.fall)
                 | ((edge_b_code == tcc_pkg::EDGE_RISE) & edge_b.rise)
                 | ((edge_b_code == tcc_pkg::EDGE_BOTH)
                    & (edge_b.rise | edge_b.fall));
  assign rev_a = ((edge_a_code == tcc_pkg::EDGE_RISE) & edge_a.fall)
               | ((edge_a_code == tcc_pkg::EDGE_FALL) & edge_a.rise);

  // -------------------------------------------------------------------------
  // compare, clear and capture events
  // -------------------------------------------------------------------------
  wire hit_a;
  wire hit_b;
  wire clr_edge;
  wire clr_match;
  wire os_trig;
  wire ovf_set;
  wire cap_a;
  wire cap_b;
  wire toggle;

  // a match fires on the tick that moves the count off the compare value,
  // so a zero compare value fires on 0000 to 0001 after overflow or a clear
  assign hit_a = tick & running & (count_r == cca_r);
  assign hit_b = tick & running & (count_r == ccb_r);
  assign clr_edge = (run_bits == tcc_pkg::RUN_CLR_EDGE) & valid_a;
  assign clr_match = (run_bits == tcc_pkg::RUN_CLR_MATCH) & hit_a;
  assign os_trig = wr_outctl & wd8[tcc_pkg::OUT_OS_TRIG_BIT]
                 & (wd8[tcc_pkg::OUT_OS_EN_BIT]
                    | outctl_r[tcc_pkg::OUT_OS_EN_BIT]);
  assign ovf_set = tick & running & (count_r == tcc_pkg::COUNT_MAX);
  assign cap_a = running & capa_mode
               & (capa_trig ? rev_a : valid_b);
  assign cap_b = running & capb_mode & valid_a;
  assign toggle = running
                & ((outctl_r[tcc_pkg::OUT_INV_A_BIT] & hit_a)
                   | (outctl_r[tcc_pkg::OUT_INV_B_BIT] & hit_b)
                   | (clr_sel & valid_a));

  // -------------------------------------------------------------------------
  // next values
  // -------------------------------------------------------------------------
  always_comb begin
    if (!running) begin
      count_nxt = tcc_pkg::COUNT_RST;
    end else if (os_trig) begin
      count_nxt = tcc_pkg::COUNT_RST;
    end else if (clr_edge | clr_match) begin
      count_nxt = tcc_pkg::COUNT_RST;
    end else if (tick) begin
      count_nxt = count_r + 16'h0001;
    end else begin
      count_nxt = count_r;
    end
  end

  // a capture always wins over a software write in the same cycle
  assign cca_nxt = cap_a ? count_r : (wr_cca ? wd16 : cca_r);
  assign ccb_nxt = cap_b ? count_r : (wr_ccb ? wd16 : ccb_r);

  // overflow flag: write 0 clears, write 1 keeps; hardware set wins
  always_comb begin
    mode_nxt = mode_r;
    if (wr_mode) begin
      mode_nxt = (wd8 & tcc_pkg::MODE_WMASK)
               | {7'h00, mode_r[tcc_pkg::MODE_OVF_BIT]
                         & wd8[tcc_pkg::MODE_OVF_BIT]};
    end
    if (ovf_set) begin
      mode_nxt[tcc_pkg::MODE_OVF_BIT] = 1'b1;
    end
  end

  always_comb begin
    out_ff_nxt = out_ff_r ^ toggle;
    if (wr_outctl & wd8[tcc_pkg::OUT_RESET_BIT]) begin
      out_ff_nxt = 1'b0;
    end
    if (wr_outctl & wd8[tcc_pkg::OUT_SET_BIT]) begin
      out_ff_nxt = 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // timer registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= tcc_pkg::COUNT_RST;
      cca_r <= tcc_pkg::CC_RST;
      ccb_r <= tcc_pkg::CC_RST;
      mode_r <= tcc_pkg::REG8_RST;
      out_ff_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      cca_r <= cca_nxt;
      ccb_r <= ccb_nxt;
      mode_r <= mode_nxt;
      out_ff_r <= out_ff_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      capctl_r <= tcc_pkg::REG8_RST;
      presc_r <= tcc_pkg::REG8_RST;
      outctl_r <= tcc_pkg::REG8_RST;
    end else begin
      if (wr_capctl) begin
        capctl_r <= wd8 & tcc_pkg::CAPCTL_WMASK;
      end
      if (wr_presc) begin
        presc_r <= wd8 & tcc_pkg::PRESC_WMASK;
      end
      if (wr_outctl) begin
        outctl_r <= wd8 & tcc_pkg::OUTCTL_WMASK;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
    end else begin
      irq_a_r <= hit_a & ~capa_mode;
      irq_b_r <= hit_b & ~capb_mode;
    end
  end

  // -------------------------------------------------------------------------
  // divider, synchronisers and tick samplers
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 3'h0;
      sync_a_r <= 2'h0;
      sync_b_r <= 2'h0;
    end else begin
      div_r <= div_r + 3'h1;
      sync_a_r <= {sync_a_r[0], timer_input_a};
      sync_b_r <= {sync_b_r[0], shared_port_pin_in};
    end
  end

  // pins are looked at once per tick, so short pulses may be missed
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      samp_a_r <= 1'b0;
      samp_b_r <= 1'b0;
    end else if (tick) begin
      samp_a_r <= sync_a_r[1];
      samp_b_r <= sync_b_r[1];
    end
  end

  // -------------------------------------------------------------------------
  // bus slave: writes take no wait, reads take one
  // -------------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aph_r <= '0;
    end else if (hready) begin
      aph_r.valid <= aphase_ok;
      aph_r.write <= hwrite;
      aph_r.mapped <= aphase_map;
      aph_r.addr <= haddr[7:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus_st_r <= tcc_pkg::BUS_IDLE;
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h00000000;
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
      case (bus_st_r)
        tcc_pkg::BUS_IDLE: begin
          if (aphase_ok & ~hwrite) begin
            bus_st_r <= tcc_pkg::BUS_RDWAIT;
            hreadyout_r <= 1'b0;
          end
        end
        tcc_pkg::BUS_RDWAIT: begin
          hrdata_r <= rd_mux;
          hreadyout_r <= 1'b1;
          bus_st_r <= tcc_pkg::BUS_IDLE;
        end
        default: begin
          bus_st_r <= tcc_pkg::BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign shared_port_pin_out = out_ff_r;
  assign shared_port_pin_oe = out_en;
  assign irq_match_a = irq_a_r;
  assign irq_match_b = irq_b_r;

  // counter register is read-only; writes to it are dropped
  wire unused_ok;
  assign unused_ok = wr_count | htrans[0] | (|hwdata[31:16]);

endmodule

`default_nettype wire

// ---- tcc_top_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module tcc_top_test;
  logic clock, reset_n, hwrite, go, hresp, hreadyout, timer_input_a;
  logic shared_port_pin_out, shared_port_pin_oe, irq_match_a, irq_match_b;
  logic [1:0] htrans;
  logic [7:0] width;
  logic [15:0] rnd, dif;
  logic [31:0] haddr, hwdata, hrdata, q, q2;
  wire pin_b = shared_port_pin_oe ? shared_port_pin_out : timer_input_a;
  int n_fail, checks_done, cyc, t_rd, t0, n_ia, n_ib, ba, bb;
  int mdl [9];
  int ix [4] = '{0, 1, 2, 8};
  logic [7:0] cap_cc [7] = '{8'h07, 8'h07, 8'h07, 8'h05, 8'h05, 8'h05, 8'h05};
  logic [7:0] cap_pr [7] = '{8'h10, 8'h00, 8'h30, 8'h10, 8'h40, 8'hF0, 8'hF0};
  int cap_kd [7] = '{0, 1, 2, 0, 1, 3, 2};
  tcc_top dut (.clock, .reset_n, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(tcc_pkg::HSIZE_WORD), .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .timer_input_a, .shared_port_pin_in(pin_b),
    .shared_port_pin_out, .shared_port_pin_oe, .irq_match_a, .irq_match_b);
  tcc_pulse_src far (.clock, .reset_n, .go, .width, .pin(timer_input_a));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_irq(string n, int e, int g);
    checks_done++;
    if (g != e) begin
      n_fail++;
      $display("unexpected %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    q = hrdata;
    t_rd = cyc;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d);
    if (a == tcc_pkg::ADDR_CCA || a == tcc_pkg::ADDR_CCB)
      mdl[a[4:2]] = d[15:0];
  endtask
  task automatic rd(logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic pulse(logic [7:0] w);
    @(posedge clock);
    width <= w;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (40) @(posedge clock);
  endtask
  task automatic mark;
    ba = n_ia;
    bb = n_ib;
  endtask
  // ---------------------------------------------------------------
  // clock, counters, watchdog
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (irq_match_a === 1'b1)
      n_ia <= n_ia + 1;
    if (irq_match_b === 1'b1)
      n_ib <= n_ib + 1;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    stop_test;
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {reset_n, hwrite, go, n_fail, checks_done} = '0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    width = 8'h04;
    rnd = 16'h001D;
    mdl = '{default: 0};
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(8'(4 * i));
      chk_word("reset value", mdl[i], q);
    end
    foreach (ix[i]) begin
      rnd = lfsr(rnd);
      wr(8'(4 * ix[i]), {~rnd, rnd});
    end
    foreach (ix[i]) begin
      rd(8'(4 * ix[i]));
      chk_word("reg readback", mdl[ix[i]], q);
    end
    $display("test registers done");
    wr(tcc_pkg::ADDR_CCA, 32'h10);
    wr(tcc_pkg::ADDR_CCB, 32'hFFF0);
    mark;
    wr(tcc_pkg::ADDR_MODE, 32'h4);
    rd(tcc_pkg::ADDR_COUNT);
    t0 = t_rd;
    q2 = q;
    wr(tcc_pkg::ADDR_CCB, 32'h40);
    rd(tcc_pkg::ADDR_COUNT);
    chk_word("count step", t_rd - t0, q - q2);
    repeat (100) @(posedge clock);
    wr(tcc_pkg::ADDR_MODE, 32'h0);
    rd(tcc_pkg::ADDR_COUNT);
    chk_word("count stop", 32'h0, q);
    rd(tcc_pkg::ADDR_CCA);
    chk_word("compare held", mdl[1], q);
    chk_irq("irq a", 1, n_ia - ba);
    chk_irq("irq b", 1, n_ib - bb);
    $display("test free run done");
    wr(tcc_pkg::ADDR_CCA, 32'h4);
    wr(tcc_pkg::ADDR_CCB, 32'h0);
    wr(tcc_pkg::ADDR_MODE, 32'hC);
    rd(tcc_pkg::ADDR_COUNT);
    chk_word("count wrap", 32'h1, {31'h0, q < 32'h5});
    mark;
    repeat (50) @(posedge clock);
    chk_irq("irq a", 10, n_ia - ba);
    chk_irq("irq b", 10, n_ib - bb);
    wr(tcc_pkg::ADDR_MODE, 32'h0);
    $display("test match clear done");
    wr(tcc_pkg::ADDR_CCA, 32'h0);
    wr(tcc_pkg::ADDR_PRESC, 32'h10);
    mark;
    wr(tcc_pkg::ADDR_MODE, 32'h8);
    repeat (3) pulse(8'h06);
    wr(tcc_pkg::ADDR_MODE, 32'h0);
    chk_irq("irq a", 4, n_ia - ba);
    chk_irq("irq b", 4, n_ib - bb);
    $display("test edge clear done");
    mark;
    wr(tcc_pkg::ADDR_MODE, 32'h4);
    repeat (200) @(posedge clock);
    wr(tcc_pkg::ADDR_OUTCTL, 32'h60);
    rd(tcc_pkg::ADDR_COUNT);
    chk_word("count clear", 32'h1, {31'h0, q < 32'h10});
    rd(tcc_pkg::ADDR_OUTCTL);
    chk_word("out control", 32'h20, q);
    wr(tcc_pkg::ADDR_MODE, 32'h0);
    wr(tcc_pkg::ADDR_OUTCTL, 32'h0);
    chk_irq("irq a", 2, n_ia - ba);
    chk_irq("irq b", 2, n_ib - bb);
    $display("test one shot done");
    for (int i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      wr(tcc_pkg::ADDR_CCA, {16'h0000, rnd});
      wr(tcc_pkg::ADDR_CAPCTL, {24'h0, cap_cc[i]});
      wr(tcc_pkg::ADDR_PRESC, {24'h0, cap_pr[i]});
      wr(tcc_pkg::ADDR_OUTCTL, (i == 6) ? 32'h1 : 32'h0);
      wr(tcc_pkg::ADDR_MODE, 32'h4);
      pulse(8'h04 + {4'h0, rnd[3:0]});
      wr(tcc_pkg::ADDR_MODE, 32'h0);
      rd(tcc_pkg::ADDR_CCA);
      q2 = q;
      rd(tcc_pkg::ADDR_CCB);
      dif = (cap_kd[i] == 1) ? q[15:0] - q2[15:0] : q2[15:0] - q[15:0];
      case (cap_kd[i])
        0, 1: chk_word("cap gap", 32'(width), 32'(dif));
        2: chk_word("capture held", {16'h0, rnd}, q2);
        default: chk_word("capture both", q, q2);
      endcase
    end
    wr(tcc_pkg::ADDR_OUTCTL, 32'h9);
    @(posedge clock);
    q = {29'h0, hresp, shared_port_pin_oe, shared_port_pin_out};
    chk_word("pin drive", 32'h3, q);
    $display("test capture done");
    stop_test;
  end
endmodule
`default_nettype wire
